// file: core/pcsr_top.sv
// Pin-configured converter control with two-wire serial result readout
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "pcsr_defines.svh"
// Function
// - Configuration only from static pins
// - Each delivered result is 24 bits
// - rate_select low 10SPS, high 80SPS
// - power_down_n low resets conversion logic
// - Each shift_clock rise presents next bit
// - ready_data_out low marks new result
// - Shift MSB first from first rising edge
// - Readout uses shift_clock and ready_data_out only
// - Calibration and sleep sequences not decoded
// - Mux pins pick one of four pairs
// - Two-channel variant uses temp_diode_enable instead
// - Single-ended measurement gives positive codes only
// - Gain pins choose 1, 2, 64, 128
// - Diode enable swaps inputs for sensing diodes
// - Oscillator runs only without fast external clock
// - Output rate scales with external clock
module pcsr_top #(
	parameter int FOUR_CH = 1,
	parameter int PER_SLOW = `PCSR_PER_SLOW,
	parameter int PER_FAST = `PCSR_PER_FAST
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Static configuration pins
	input wire logic power_down_n,
	input wire logic rate_select,
	input wire logic gain_sel_msb,
	input wire logic gain_sel_lsb,
	input wire logic mux_sel_msb,
	input wire logic mux_sel_lsb,
	input wire logic temp_diode_enable,
	input wire logic single_ended_mode,
	input wire logic ext_clock_pin,
	// Filter output, same clock
	input wire pcsr_pkg::pcsr_word_t conv_sample,
	// Serial link
	input wire logic shift_clock,
	output logic ready_data_out,
	// Analog front-end controls
	output logic converter_power_on,
	output logic [1:0] analog_pair_sel,
	output logic input_connect,
	output logic diode_route,
	output logic [7:0] gain_factor,
	output logic osc_enable
);
	import pcsr_pkg::*;

	localparam int W = `PCSR_WORD_BITS;
	localparam int NS = 10;
	// Sync vector bit positions
	localparam int I_PD = 0, I_RATE = 1, I_GM = 2, I_GL = 3, I_MM = 4;
	localparam int I_ML = 5, I_TEMP = 6, I_SE = 7, I_EXT = 8, I_TOG = 9;

	pcsr_state_e state; // Readout state
	pcsr_word_t hold; // Word being read out
	logic link_arm; // Releases link-side reset
	logic [NS-1:0] sync_a; // First synchroniser stage
	logic [NS-1:0] sync_b; // Second synchroniser stage
	logic tog_prev; // Last seen edge toggle
	logic edge_d; // Edge seen one cycle ago
	logic [4:0] edge_cnt; // Edges seen in this readout
	logic ext_prev; // Last external clock level
	logic ext_mode; // External clock detected
	logic [15:0] det_cnt; // Detection window timer
	logic [15:0] det_edges; // Edges in window
	logic [7:0] osc_cnt; // Internal oscillator divider
	logic [18:0] conv_cnt; // Conversion period counter
	logic kick; // Software-forced conversion
	logic edge_tog; // Flips on every shift edge

	// Two-flop synchronisers for every foreign input
	wire [NS-1:0] raw_in = {edge_tog, ext_clock_pin,
		single_ended_mode, temp_diode_enable, mux_sel_lsb, mux_sel_msb,
		gain_sel_lsb, gain_sel_msb, rate_select, power_down_n};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= '0;
			sync_b <= '0;
		end else if (clk_en) begin
			sync_a <= raw_in;
			sync_b <= sync_a;
		end
	end

	// Synchronised pin levels
	wire pd_s = sync_b[I_PD];
	wire ext_s = sync_b[I_EXT];
	wire edge_seen = sync_b[I_TOG] ^ tog_prev;
	wire ext_rise = ext_s & ~ext_prev;
	// Variant decides what the shared pin means
	wire diode_on = (FOUR_CH == 0) && sync_b[I_TEMP];
	wire pair_msb = (FOUR_CH != 0) && sync_b[I_MM];
	wire [1:0] gain_code = {sync_b[I_GM], sync_b[I_GL]};
	wire [7:0] gain_dec = (gain_code == 2'h0) ? `PCSR_GAIN_X1 :
		(gain_code == 2'h1) ? `PCSR_GAIN_X2 :
		(gain_code == 2'h2) ? `PCSR_GAIN_X64 : `PCSR_GAIN_X128;
	// Negative codes cannot occur against a grounded input
	wire pcsr_word_t shaped = (sync_b[I_SE] && conv_sample[W-1]) ?
		'0 : conv_sample;
	// Period in converter clocks, picked by the rate pin
	wire [18:0] period = sync_b[I_RATE] ? 19'(PER_FAST - 1) :
		19'(PER_SLOW - 1);
	// Converter clock tick: external edges or divided pclk
	wire osc_tick = (osc_cnt == 8'(`PCSR_OSC_DIV - 1));
	wire conv_tick = ext_mode ? ext_rise : osc_tick;
	wire conv_evt = (conv_tick && conv_cnt == period) || kick;
	wire last_edge = (edge_cnt == 5'(W));
	wire [4:0] msb_idx = 5'(W - 1) - edge_cnt;

	// Front-end control outputs, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_power_on <= 1'b0;
			analog_pair_sel <= 2'h0;
			input_connect <= 1'b0;
			diode_route <= 1'b0;
			gain_factor <= `PCSR_GAIN_X1;
			osc_enable <= 1'b1;
		end else if (clk_en) begin
			converter_power_on <= pd_s;
			analog_pair_sel <= {pair_msb, sync_b[I_ML]};
			input_connect <= pd_s && !diode_on;
			diode_route <= pd_s && diode_on;
			gain_factor <= gain_dec;
			osc_enable <= !ext_mode;
		end
	end

	// Clock detect: count external edges over a fixed window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev <= 1'b0;
			ext_mode <= 1'b0;
			det_cnt <= '0;
			det_edges <= '0;
		end else if (clk_en) begin
			ext_prev <= ext_s;
			if (det_cnt == 16'(`PCSR_DET_CYC - 1)) begin
				// Above about 200kHz counts as external clock
				ext_mode <= det_edges > 16'(`PCSR_DET_EDGES);
				det_cnt <= '0;
				det_edges <= '0;
			end else begin
				det_cnt <= det_cnt + 16'h1;
				det_edges <= det_edges + 16'(ext_rise);
			end
		end
	end

	// Conversion timer, held in reset while powered down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_cnt <= '0;
			conv_cnt <= '0;
		end else if (clk_en) begin
			osc_cnt <= osc_tick ? 8'h0 : osc_cnt + 8'h1;
			if (!pd_s) begin
				conv_cnt <= '0;
			end else if (conv_tick) begin
				conv_cnt <= (conv_cnt >= period) ? 19'h0 : conv_cnt + 19'h1;
			end
		end
	end

	// Readout sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= PCSR_IDLE;
			hold <= '0;
			link_arm <= 1'b0;
			tog_prev <= 1'b0;
			edge_d <= 1'b0;
			edge_cnt <= '0;
			ready_data_out <= 1'b1;
		end else if (clk_en) begin
			tog_prev <= link_arm ? sync_b[I_TOG] : 1'b0;
			edge_d <= edge_seen && link_arm;
			if (!pd_s) begin
				state <= PCSR_IDLE;
				link_arm <= 1'b0;
				ready_data_out <= 1'b1;
			end else begin
				unique case (state)
					PCSR_IDLE, PCSR_DONE: begin
						if (conv_evt) begin
							hold <= shaped;
							link_arm <= 1'b1;
							edge_cnt <= '0;
							ready_data_out <= 1'b0;
							state <= PCSR_READY;
						end
					end
					PCSR_READY: begin
						// Fresher result replaces one not yet touched
						if (conv_evt && !edge_seen) begin
							hold <= shaped;
						end
						if (edge_seen) begin
							state <= PCSR_SHIFT;
						end
					end
					PCSR_SHIFT: begin
						// A result during readout is dropped
						if (edge_d) begin
							// Bit picked here, so the word never crosses
							ready_data_out <= hold[msb_idx];
							edge_cnt <= edge_cnt + 5'h1;
						end
						if (last_edge) begin
							link_arm <= 1'b0;
							state <= PCSR_DONE;
						end
					end
				endcase
			end
		end
	end

	// Link side: only a toggle crosses; other sequences not decoded
	always_ff @(posedge shift_clock or negedge link_arm) begin
		if (!link_arm) begin
			edge_tog <= 1'b0;
		end else begin
			edge_tog <= ~edge_tog;
		end
	end

	// APB slave: zero wait, read data captured in setup phase
	wire setup = psel && !penable;
	wire wr_acc = psel && penable && pwrite && pready;
	wire hit_st = (paddr == `PCSR_OFF_STATUS);
	wire hit_res = (paddr == `PCSR_OFF_RESULT);
	wire hit_kick = (paddr == `PCSR_OFF_KICK);
	wire mapped = hit_st || hit_res || hit_kick;
	// Configuration stays pin-only; nothing here sets it
	wire [31:0] status = 32'({sync_b[I_SE], diode_on, gain_code,
		analog_pair_sel, sync_b[I_RATE], pd_s, ext_mode, state});
	wire [31:0] rd_mux = hit_st ? status :
		hit_res ? {8'h0, hold} : 32'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			kick <= 1'b0;
		end else if (clk_en) begin
			pready <= 1'b1;
			if (setup) begin
				prdata <= rd_mux;
				pslverr <= !mapped;
			end
			kick <= wr_acc && hit_kick && pwdata[0] && pd_s;
		end
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !clk_en);

	property p_ready_low;
		(state == PCSR_READY) |-> !ready_data_out;
	endproperty
	a_ready_low: assert property (p_ready_low)
		else $error("ready not low with result waiting");

	property p_pd_reset;
		!pd_s |=> (state == PCSR_IDLE) && ready_data_out && !link_arm;
	endproperty
	a_pd_reset: assert property (p_pd_reset)
		else $error("power down did not reset readout");

	property p_gain;
		##1 gain_factor == ($past(gain_code) == 2'h3 ? 8'h80 :
			$past(gain_code) == 2'h2 ? 8'h40 : 8'h01 << $past(gain_code));
	endproperty
	a_gain: assert property (p_gain)
		else $error("gain factor mismatch");

	property p_pair;
		##1 analog_pair_sel[1] == ((FOUR_CH != 0) && $past(sync_b[I_MM]));
	endproperty
	a_pair: assert property (p_pair)
		else $error("pair select mismatch");

	property p_diode;
		diode_route |-> !input_connect && (FOUR_CH == 0);
	endproperty
	a_diode: assert property (p_diode)
		else $error("diodes routed with inputs connected");

	property p_osc;
		$rose(ext_mode) |=> !osc_enable;
	endproperty
	a_osc: assert property (p_osc)
		else $error("oscillator left on with external clock");

	property p_clamp;
		(state != PCSR_SHIFT && !edge_seen && conv_evt && pd_s &&
			sync_b[I_SE] && conv_sample[W-1]) |=> hold == '0;
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("negative code in single-ended mode");

	sequence s_shift_end;
		(state == PCSR_SHIFT) && last_edge;
	endsequence
	property p_shift24;
		s_shift_end |=> (state == PCSR_DONE) && !link_arm;
	endproperty
	a_shift24: assert property (p_shift24)
		else $error("readout did not end after 24 bits");

	property p_period;
		(conv_tick && conv_cnt == period && !kick && pd_s &&
			state == PCSR_IDLE) |=> state == PCSR_READY;
	endproperty
	a_period: assert property (p_period)
		else $error("period end gave no result");
endmodule : pcsr_top

// file: pkg/pcsr_defines.svh
// Constants for the pin-configured converter control and serial readout
`ifndef PCSR_DEFINES_SVH
`define PCSR_DEFINES_SVH
// Register byte offsets
`define PCSR_OFF_STATUS 12'h000
`define PCSR_OFF_RESULT 12'h004
`define PCSR_OFF_KICK 12'h008
// Status field positions
`define PCSR_ST_STATE 0
`define PCSR_ST_EXT 4
`define PCSR_ST_PWR 5
`define PCSR_ST_RATE 6
`define PCSR_ST_PAIR 7
`define PCSR_ST_GAIN 9
`define PCSR_ST_DIODE 11
`define PCSR_ST_SE 12
// Result word width
`define PCSR_WORD_BITS 24
// Clock timing
`define PCSR_CLK_NS 10
`define PCSR_NOM_CLK_HZ 4915200
`define PCSR_RATE_SLOW_SPS 10
`define PCSR_RATE_FAST_SPS 80
`define PCSR_PER_SLOW (`PCSR_NOM_CLK_HZ / `PCSR_RATE_SLOW_SPS)
`define PCSR_PER_FAST (`PCSR_NOM_CLK_HZ / `PCSR_RATE_FAST_SPS)
// Clock detection window and threshold
`define PCSR_DET_NS 10000
`define PCSR_DET_CYC (`PCSR_DET_NS / `PCSR_CLK_NS)
`define PCSR_DET_KHZ 200
`define PCSR_DET_EDGES (`PCSR_DET_KHZ * `PCSR_DET_NS / 1000000)
// Internal oscillator divider from pclk
`define PCSR_OSC_DIV 20
// Gain factors
`define PCSR_GAIN_X1 8'h01
`define PCSR_GAIN_X2 8'h02
`define PCSR_GAIN_X64 8'h40
`define PCSR_GAIN_X128 8'h80
`endif

// file: pkg/pcsr_pkg.sv
// Types for the pin-configured converter control and serial readout
package pcsr_pkg;
	// Readout states, one-hot
	typedef enum logic [3:0] {
		PCSR_IDLE = 4'h1,
		PCSR_READY = 4'h2,
		PCSR_SHIFT = 4'h4,
		PCSR_DONE = 4'h8
	} pcsr_state_e;
	// One conversion result
	typedef logic [23:0] pcsr_word_t;
endpackage : pcsr_pkg

// file: sim/pcsr_host_model.sv
// Host-side reader that clocks results out of the serial link
`timescale 1ns/10ps
module pcsr_host_model (
	// Handshake with the bench
	input wire logic start,
	output logic done,
	// Serial link
	input wire logic ready_data_out,
	output logic shift_clock,
	output pcsr_pkg::pcsr_word_t word
);
	import pcsr_pkg::*;
	// Link clock stands low outside frames
	initial begin
		shift_clock = 1'b0;
		done = 1'b0;
		word = 24'h000000;
	end
	// One frame per request from the bench
	always begin
		wait (start === 1'b1);
		// Only a low line marks a fresh result
		wait (ready_data_out === 1'b0);
		// Phase unrelated to the system clock
		#7;
		// 32 ns clock; a bit settles ~40 ns after its rise, so it is
		// taken in the low phase of the following period
		for (int b = 0; b <= 24; b++) begin
			shift_clock = (b < 24);
			#16;
			shift_clock = 1'b0;
			#2;
			if (b > 0) begin
				word = {word[22:0], ready_data_out};
			end
			#14;
		end
		done = 1'b1;
		wait (start === 1'b0);
		done = 1'b0;
	end
endmodule : pcsr_host_model

// file: sim/pcsr_top_bench.sv
// Self-checking bench for converter control and serial readout
`timescale 1ns/10ps
`include "pcsr_defines.svh"
module pcsr_top_bench;
	import pcsr_pkg::*;
	// Clock, reset and bus
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err;
	// Static pins
	logic power_down_n = 1'b1, rate_select = 1'b0, single_ended_mode = 1'b0;
	logic gain_sel_msb = 1'b0, gain_sel_lsb = 1'b0, temp_diode_enable = 1'b0;
	logic mux_sel_msb = 1'b0, mux_sel_lsb = 1'b0;
	logic ext_clock_pin = 1'b0, ext_run = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] ext_cnt = 8'h00;
	pcsr_word_t conv_sample = 24'h000000, host_word;
	// Link and front end
	logic shift_clock, ready_data_out, host_start = 1'b0, host_done;
	logic converter_power_on, input_connect, diode_route, osc_enable;
	logic [1:0] analog_pair_sel;
	logic [7:0] gain_factor;
	logic [7:0] gains [4] = '{8'h01, 8'h02, 8'h40, 8'h80};
	int num_errors = 0;
	int check_count = 0;
	always #5 pclk = ~pclk;
	// External converter clock, about 1.5 MHz while running
	always @(posedge pclk) begin
		ext_cnt <= ext_cnt + 8'h01;
		ext_clock_pin <= ext_run & ext_cnt[5];
	end
	// Short conversion periods keep the run brief
	pcsr_top #(.FOUR_CH(1), .PER_SLOW(40), .PER_FAST(20)) i_pcsr_top (
		.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .power_down_n, .rate_select,
		.gain_sel_msb, .gain_sel_lsb, .mux_sel_msb, .mux_sel_lsb,
		.temp_diode_enable, .single_ended_mode, .ext_clock_pin, .conv_sample,
		.shift_clock, .ready_data_out, .converter_power_on, .analog_pair_sel,
		.input_connect, .diode_route, .gain_factor, .osc_enable);
	pcsr_host_model i_pcsr_host_model (.start(host_start), .done(host_done),
		.ready_data_out, .shift_clock, .word(host_word));
	// Compare and count
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	// One APB transfer; read data and error land in rd and err
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only pready or the watchdog ends the access phase
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("bus answer", 32'h1, {31'h0, pready});
	endtask : apb
	// Force a conversion, then read it serially and through the bus
	task automatic readout(input pcsr_word_t s, input pcsr_word_t exp);
		conv_sample <= s;
		apb(1'b1, `PCSR_OFF_KICK, 32'h1);
		repeat (4) @(posedge pclk);
		host_start <= 1'b1;
		wait (host_done === 1'b1);
		@(posedge pclk);
		host_start <= 1'b0;
		chk("serial word", {8'h00, exp}, {8'h00, host_word});
		apb(1'b0, `PCSR_OFF_RESULT, 32'h0);
		chk("result reg", {8'h00, exp}, rd);
	endtask : readout
	// Verdict and end of run
	task automatic tally_and_finish();
		if (num_errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("idle line", 32'h1, {31'h0, ready_data_out});
		apb(1'b0, `PCSR_OFF_STATUS, 32'h0);
		chk("idle state", 32'h1, {28'h0, rd[3:0]});
		// Every gain and pair code
		for (int i = 0; i < 4; i++) begin
			{gain_sel_msb, gain_sel_lsb} <= i[1:0];
			{mux_sel_msb, mux_sel_lsb} <= i[1:0];
			repeat (5) @(posedge pclk);
			chk("gain", {24'h0, gains[i]}, {24'h0, gain_factor});
			chk("pair", i, {30'h0, analog_pair_sel});
		end
		// Enable low freezes the pin path
		clk_en <= 1'b0;
		{gain_sel_msb, gain_sel_lsb} <= 2'h0;
		repeat (5) @(posedge pclk);
		chk("frozen gain", 32'h80, {24'h0, gain_factor});
		clk_en <= 1'b1;
		repeat (5) @(posedge pclk);
		chk("thawed gain", 32'h1, {24'h0, gain_factor});
		temp_diode_enable <= 1'b1;
		rate_select <= 1'b1;
		repeat (5) @(posedge pclk);
		chk("diode route", 32'h0, {31'h0, diode_route});
		chk("input connect", 32'h1, {31'h0, input_connect});
		apb(1'b0, `PCSR_OFF_STATUS, 32'h0);
		chk("rate", 32'h1, {31'h0, rd[`PCSR_ST_RATE]});
		apb(1'b0, 12'h00c, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, `PCSR_OFF_RESULT, 32'hffffffff);
		apb(1'b0, `PCSR_OFF_RESULT, 32'h0);
		chk("result write", 32'h0, rd);
		chk("osc on", 32'h1, {31'h0, osc_enable});
		ext_run <= 1'b1;
		repeat (2500) @(posedge pclk);
		chk("osc off", 32'h0, {31'h0, osc_enable});
		ext_run <= 1'b0;
		repeat (2500) @(posedge pclk);
		chk("osc back", 32'h1, {31'h0, osc_enable});
		readout(24'ha5c3f1, 24'ha5c3f1);
		readout(24'h5a3c0f, 24'h5a3c0f);
		single_ended_mode <= 1'b1;
		readout(24'h800123, 24'h000000);
		readout(24'h7fff01, 24'h7fff01);
		power_down_n <= 1'b0;
		repeat (5) @(posedge pclk);
		chk("power on", 32'h0, {31'h0, converter_power_on});
		apb(1'b1, `PCSR_OFF_KICK, 32'h1);
		repeat (10) @(posedge pclk);
		chk("held line", 32'h1, {31'h0, ready_data_out});
		power_down_n <= 1'b1;
		repeat (5) @(posedge pclk);
		chk("power back", 32'h1, {31'h0, converter_power_on});
		tally_and_finish();
	end
	// Watchdog, well beyond the expected run
	initial begin
		#400000;
		num_errors++;
		tally_and_finish();
	end
endmodule : pcsr_top_bench
